/* File: spi_ctrl_pkg.sv */
// Behaviour
// - miso is input as master, output as selected slave, released when deselected
// - both data lines shift most significant bit first
// - one transfer swaps exactly one byte over eight serial clocks
// - master drives sck out, slave takes sck in
// - master puts each bit on mosi half a period before its sampling edge, except the phase 1 first bit, which goes out a whole period before
// - master rate bits divide bus clock by 2, 4, 16, 32; ignored as slave
// - phase 0 slave shift clock is select or sck; phase 1 select may stay low
// - phase 0 slave starts at select fall; first sck edge samples first bit
// - received byte replaces sent byte in shift register; one done flag
// - data writes during a transfer are dropped and set write collision
// - master sck idles until data write, gives eight clocks, idles again
// - polarity 0 idles sck low, polarity 1 idles sck high
// - slave copies each received byte to read buffer except an overrun byte; write waits for master clocks
// - control bits: irq enable, system enable, role select (1 is master)
// - done flag sets at byte end; irq while done and irq enable
// - done clears on status read then data access; writes blocked until that read
// - collision window: phase 0 select low span, phase 1 first edge to done
// - write collision clears on status read then data access
// - mode fault sets as master with select low; clears enable and role, irq
// - mode fault clears on status read then control write
// - status bits 5 and 3..0 read zero
// - byte completing while done still set is an overrun and is dropped
// - done flag sets in master and slave alike
package spi_ctrl_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_DATA = 2'h2;

	localparam int CTRL_IRQ_ENABLE = 7;
	localparam int CTRL_SYSTEM_ENABLE = 6;
	localparam int CTRL_ROLE_SELECT = 4;
	localparam int CTRL_CPOL = 3;
	localparam int CTRL_CPHA = 2;
	localparam int CTRL_RATE_HI = 1;
	localparam int CTRL_RATE_LO = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	localparam int STAT_DONE = 7;
	localparam int STAT_WRITE_COLLISION_FLAG = 6;
	localparam int STAT_MODE_FAULT_FLAG = 4;

	// ----------------------------------------
	// timing counts (half sck period minus one, in bus clocks)
	// ----------------------------------------
	localparam logic [1:0] RATE_DIV2 = 2'h0;
	localparam logic [1:0] RATE_DIV4 = 2'h1;
	localparam logic [1:0] RATE_DIV16 = 2'h2;
	localparam logic [1:0] RATE_DIV32 = 2'h3;
	localparam logic [3:0] HALF_TC_DIV2 = 4'h0;
	localparam logic [3:0] HALF_TC_DIV4 = 4'h1;
	localparam logic [3:0] HALF_TC_DIV16 = 4'h7;
	localparam logic [3:0] HALF_TC_DIV32 = 4'hf;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [4:0] LAST_TOGGLE = 5'h0f;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MST_IDLE = 2'b01,
		MST_RUN = 2'b10
	} master_state_type;

	typedef struct packed {
		logic irq_enable;
		logic system_enable;
		logic role_select;
		logic cpol;
		logic cpha;
		logic [1:0] rate;
		logic done;
		logic write_collision_flag;
		logic mode_fault_flag;
		logic arm_done;
		logic arm_write_collision_flag;
		logic arm_mode_fault_flag;
		logic [7:0] shift;
		logic [7:0] rbuf;
		logic [7:0] rdata;
		logic in_bit;
		logic out_bit;
		logic [2:0] bit_cnt;
		master_state_type mst;
		logic [3:0] div;
		logic [4:0] tog;
		logic k;
		logic k_prev;
		logic slave_active;
		logic overrun;
	} state_type;

endpackage

/* File: spi_ctrl.sv */
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module spi_ctrl
	import spi_ctrl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_overrun,
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe,
	input wire logic i_mosi,
	output logic o_mosi,
	output logic o_mosi_oe,
	input wire logic i_miso,
	output logic o_miso,
	output logic o_miso_oe,
	input wire logic i_ss_n
);

	state_type s;
	state_type next_s;

	// ----------------------------------------
	// decode and role
	// ----------------------------------------
	logic ctrl_wr;
	logic stat_rd;
	logic data_wr;
	logic data_acc;
	logic master;
	logic slave;
	logic [3:0] half_tc;
	logic tick;
	logic slave_k;
	logic lead;
	logic trail;
	logic sample_edge;
	logic shift_edge;
	logic din;
	logic busy;
	logic blocked;
	logic start;
	logic complete;
	logic clear_done;
	logic clear_write_collision_flag;
	logic clear_mode_fault_flag;
	logic mode_fault_flag_event;
	logic [7:0] rx_byte;
	logic [7:0] status_val;

	assign ctrl_wr = i_wr && (i_addr == ADDR_CONTROL);
	assign stat_rd = i_rd && (i_addr == ADDR_STATUS);
	assign data_wr = i_wr && (i_addr == ADDR_DATA);
	assign data_acc = (i_wr || i_rd) && (i_addr == ADDR_DATA);
	assign master = s.system_enable & s.role_select;
	assign slave = s.system_enable & ~s.role_select;

	always_comb begin
		case (s.rate)
			RATE_DIV2: half_tc = HALF_TC_DIV2;
			RATE_DIV4: half_tc = HALF_TC_DIV4;
			RATE_DIV16: half_tc = HALF_TC_DIV16;
			RATE_DIV32: half_tc = HALF_TC_DIV32;
			default: half_tc = HALF_TC_DIV2;
		endcase
	end

	// ----------------------------------------
	// serial clock edges
	// ----------------------------------------
	// polarity folded out so edge logic sees an idle-low clock
	assign tick = (s.mst == MST_RUN) && (s.div == half_tc);
	// phase 0: select ored in, so a deselected slave never sees edges
	assign slave_k = (i_sck ^ s.cpol) | (~s.cpha & i_ss_n);
	// select rising would look like an edge; gate it out
	assign lead = master ? (tick & ~s.k) : (slave & ~i_ss_n & slave_k & ~s.k_prev);
	assign trail = master ? (tick & s.k) : (slave & ~i_ss_n & ~slave_k & s.k_prev);
	assign sample_edge = s.cpha ? trail : lead;
	assign shift_edge = s.cpha ? lead : trail;
	assign din = s.role_select ? i_miso : i_mosi;
	assign rx_byte = {s.shift[6:0], din};
	assign complete = sample_edge && (s.bit_cnt == LAST_BIT);

	// ----------------------------------------
	// transfer window and flag handshakes
	// ----------------------------------------
	always_comb begin
		if (master) begin
			busy = (s.mst == MST_RUN);
		end else if (slave) begin
			busy = s.cpha ? s.slave_active : ~i_ss_n;
		end else begin
			busy = 1'b0;
		end
	end

	assign blocked = s.done && !s.arm_done;
	assign start = data_wr && !busy && !blocked && master && (s.mst == MST_IDLE);
	assign clear_done = data_acc && s.arm_done;
	assign clear_write_collision_flag = data_acc && s.arm_write_collision_flag;
	assign clear_mode_fault_flag = ctrl_wr && s.arm_mode_fault_flag;
	assign mode_fault_flag_event = master && !i_ss_n;

	always_comb begin
		status_val = 8'h00;
		status_val[STAT_DONE] = s.done;
		status_val[STAT_WRITE_COLLISION_FLAG] = s.write_collision_flag;
		status_val[STAT_MODE_FAULT_FLAG] = s.mode_fault_flag;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.overrun = 1'b0;
		next_s.k_prev = slave_k;

		// slave: a dropped select abandons any partial byte
		if (slave && i_ss_n) begin
			next_s.bit_cnt = 3'h0;
			next_s.slave_active = 1'b0;
		end
		if (slave && s.cpha && shift_edge) begin
			next_s.slave_active = 1'b1;
		end

		// shift engine shared by both roles
		if (sample_edge) begin
			next_s.in_bit = din;
			next_s.bit_cnt = s.bit_cnt + 3'h1;
		end
		if (shift_edge && (s.bit_cnt != 3'h0)) begin
			next_s.shift = {s.shift[6:0], s.in_bit};
		end
		if (complete) begin
			next_s.shift = rx_byte;
			next_s.slave_active = 1'b0;
			if (s.done && !clear_done) begin
				next_s.overrun = 1'b1;
			end else begin
				next_s.rbuf = rx_byte;
			end
		end

		// master clock sequencer
		case (s.mst)
			MST_IDLE: begin
				next_s.div = 4'h0;
				next_s.tog = 5'h00;
				next_s.k = 1'b0;
				if (master) begin
					next_s.bit_cnt = 3'h0;
				end
				if (start) begin
					next_s.mst = MST_RUN;
				end
			end
			MST_RUN: begin
				if (!master) begin
					next_s.mst = MST_IDLE;
				end else if (tick) begin
					next_s.div = 4'h0;
					next_s.k = ~s.k;
					next_s.tog = s.tog + 5'h01;
					if (s.tog == LAST_TOGGLE) begin
						next_s.mst = MST_IDLE;
					end
				end else begin
					next_s.div = s.div + 4'h1;
				end
			end
			default: next_s.mst = MST_IDLE;
		endcase

		// data writes: no write buffer, so a busy shifter drops it
		if (data_wr) begin
			if (busy) begin
				next_s.write_collision_flag = 1'b1;
			end else if (!blocked) begin
				next_s.shift = i_wdata;
				next_s.bit_cnt = 3'h0;
			end
		end

		// data line holds across a sampling edge, since the far side latches right there
		if (!sample_edge) begin
			next_s.out_bit = next_s.shift[7];
		end

		// flags: arm on a status read that sees them, set wins over clear
		if (stat_rd) begin
			next_s.arm_done = s.done;
			next_s.arm_write_collision_flag = s.write_collision_flag;
			next_s.arm_mode_fault_flag = s.mode_fault_flag;
		end
		if (clear_done) begin
			next_s.done = 1'b0;
			next_s.arm_done = 1'b0;
		end
		if (complete) begin
			next_s.done = 1'b1;
		end
		if (clear_write_collision_flag) begin
			next_s.write_collision_flag = 1'b0;
			next_s.arm_write_collision_flag = 1'b0;
		end
		if (data_wr && busy) begin
			next_s.write_collision_flag = 1'b1;
		end

		// control register
		if (ctrl_wr) begin
			next_s.irq_enable = i_wdata[CTRL_IRQ_ENABLE];
			next_s.system_enable = i_wdata[CTRL_SYSTEM_ENABLE];
			next_s.role_select = i_wdata[CTRL_ROLE_SELECT];
			next_s.cpol = i_wdata[CTRL_CPOL];
			next_s.cpha = i_wdata[CTRL_CPHA];
			next_s.rate = {i_wdata[CTRL_RATE_HI], i_wdata[CTRL_RATE_LO]};
		end
		if (clear_mode_fault_flag) begin
			next_s.mode_fault_flag = 1'b0;
			next_s.arm_mode_fault_flag = 1'b0;
		end
		// fault overrides the enable and role bits of any control write in the same cycle
		if (mode_fault_flag_event) begin
			next_s.mode_fault_flag = 1'b1;
			next_s.system_enable = 1'b0;
			next_s.role_select = 1'b0;
		end

		// read port: data valid only in the cycle after the strobe
		next_s.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				ADDR_CONTROL: next_s.rdata = {s.irq_enable, s.system_enable, 1'b0, s.role_select,
					s.cpol, s.cpha, s.rate};
				ADDR_STATUS: next_s.rdata = status_val;
				ADDR_DATA: next_s.rdata = s.rbuf;
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s <= '0;
			s.irq_enable <= CONTROL_RESET[CTRL_IRQ_ENABLE];
			s.system_enable <= CONTROL_RESET[CTRL_SYSTEM_ENABLE];
			s.role_select <= CONTROL_RESET[CTRL_ROLE_SELECT];
			s.cpol <= CONTROL_RESET[CTRL_CPOL];
			s.cpha <= CONTROL_RESET[CTRL_CPHA];
			s.rate <= CONTROL_RESET[1:0];
			s.mst <= MST_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// pins and outputs
	// ----------------------------------------
	assign o_sck = s.k ^ s.cpol;
	assign o_sck_oe = master;
	assign o_mosi = s.out_bit;
	assign o_mosi_oe = master;
	assign o_miso = s.out_bit;
	assign o_miso_oe = slave & ~i_ss_n;
	assign o_irq = s.irq_enable & (s.done | s.mode_fault_flag);
	assign o_overrun = s.overrun;
	assign o_rdata = s.rdata;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_quiet7;
		(!tick)[*7];
	endsequence

	property p_miso_dir;
		o_miso_oe |-> (!s.role_select && !i_ss_n && s.system_enable);
	endproperty
	a_miso_dir: assert property (p_miso_dir) else $error("miso driven while master or deselected");

	property p_idle_level;
		(master && s.mst == MST_IDLE) |-> (o_sck == s.cpol);
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("sck not at idle level");

	property p_rate16;
		(tick && master && s.rate == RATE_DIV16 && s.tog != LAST_TOGGLE && !ctrl_wr && i_ss_n)
			|=> s_quiet7 ##1 tick;
	endproperty
	a_rate16: assert property (p_rate16) else $error("divide by 16 half period wrong");

	property p_start;
		start |=> (s.mst == MST_RUN) && (s.shift == $past(i_wdata));
	endproperty
	a_start: assert property (p_start) else $error("write did not start master");

	property p_collision;
		(data_wr && busy) |=> s.write_collision_flag;
	endproperty
	a_collision: assert property (p_collision) else $error("collision not flagged");

	property p_irq;
		$rose(s.done) && s.irq_enable |-> o_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("no interrupt on done");

	property p_blocked;
		(data_wr && blocked && !busy) |=> (s.mst == MST_IDLE) && $stable(s.done);
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked write took effect");

	property p_fault;
		$rose(s.mode_fault_flag) |-> (!s.system_enable && !s.role_select && !o_sck_oe);
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault left block enabled");

	property p_status_zero;
		stat_rd |=> (o_rdata[5] == 1'b0) && (o_rdata[3:0] == 4'h0);
	endproperty
	a_status_zero: assert property (p_status_zero) else $error("unused status bits set");

	property p_rbuf;
		(complete && !s.done) |=> s.done && (s.rbuf == $past(rx_byte));
	endproperty
	a_rbuf: assert property (p_rbuf) else $error("received byte not buffered");

	property p_mosi_hold;
		(master && sample_edge) |=> $stable(o_mosi);
	endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved on a sampling edge");

endmodule

/* File: spi_peer.sv */
`timescale 1ns/1ps
// ----------------------------------------
// far side: slave while the block leads, master otherwise
// ----------------------------------------
module spi_peer (
	input wire logic i_clk,
	input wire logic i_sck,
	input wire logic i_mosi,
	input wire logic i_miso,
	output logic o_sck,
	output logic o_mosi,
	output logic o_miso,
	output logic o_ss_n
);
	logic on = 1'b0;
	logic pha = 1'b0;
	logic [7:0] tx = 8'h00;
	logic [7:0] rx = 8'h00;
	int ne = 0;
	initial begin
		o_sck = 1'b0;
		o_mosi = 1'b0;
		o_miso = 1'b0;
		o_ss_n = 1'b1;
	end
	// released miso keeps changing so a stale bit never passes
	always @(posedge i_clk) begin
		if (!on)
			o_miso <= ~o_miso;
	end
	// slave reacts to the clock pin itself, not to the bus clock
	always @(i_sck) begin
		if (on) begin
			ne = ne + 1;
			if ((ne % 2) == (pha ? 0 : 1))
				rx = {rx[6:0], i_mosi};
			else if (ne < 16)
				o_miso = tx[7 - ne / 2];
		end
	end
	task automatic arm(input logic [7:0] t, input logic cp, input logic ph);
		pha = ph;
		tx = t;
		rx = 8'h00;
		ne = 0;
		o_sck = cp;
		o_miso <= t[7];
		on = 1'b1;
	endtask
	// polarity 0 only; four bus clocks per clock level
	task automatic xfer(input logic [7:0] t, input logic ph, output logic [7:0] r);
		on = 1'b0;
		@(posedge i_clk);
		o_ss_n <= 1'b0;
		o_mosi <= t[7];
		for (int i = 0; i < 8; i++) begin
			repeat (4) @(posedge i_clk);
			o_sck <= 1'b1;
			if (ph)
				o_mosi <= t[7 - i];
			else
				r[7 - i] = i_miso;
			repeat (4) @(posedge i_clk);
			o_sck <= 1'b0;
			if (ph)
				r[7 - i] = i_miso;
			else if (i < 7)
				o_mosi <= t[6 - i];
		end
		repeat (4) @(posedge i_clk);
		o_ss_n <= 1'b1;
		o_mosi <= ~o_mosi;
	endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import spi_ctrl_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pol = 1'b0;
	logic ovr_seen = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, pr;
	logic irq, ovr, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_sck, p_mosi, p_miso, ss_n;
	logic sck_w, mosi_w, miso_w, sck_q;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int edges = 0;
	int act = 0;
	int e0, a0, h;
	assign sck_w = sck_oe ? sck_o : p_sck;
	assign mosi_w = mosi_oe ? mosi_o : p_mosi;
	assign miso_w = miso_oe ? miso_o : p_miso;
	spi_ctrl spi_ctrl_i (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_irq(irq), .o_overrun(ovr), .i_sck(sck_w), .o_sck(sck_o), .o_sck_oe(sck_oe),
		.i_mosi(mosi_w), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe), .i_miso(miso_w), .o_miso(miso_o),
		.o_miso_oe(miso_oe), .i_ss_n(ss_n));
	spi_peer spi_peer_i (.i_clk(clk), .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .o_sck(p_sck),
		.o_mosi(p_mosi), .o_miso(p_miso), .o_ss_n(ss_n));
	initial begin
		forever #50 clk = ~clk;
	end
	// ----------------------------------------
	// line monitor and hang guard
	// ----------------------------------------
	always @(posedge clk) begin
		sck_q <= sck_w;
		cyc <= cyc + 1;
		if (sck_w !== sck_q)
			edges <= edges + 1;
		if (sck_oe === 1'b1 && sck_o !== pol)
			act <= act + 1;
		if (ovr === 1'b1)
			ovr_seen <= 1'b1;
		if (cyc == 20000) begin
			errors = errors + 1;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", s, e, g);
			errors++;
		end
	endtask
	task automatic wreg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [1:0] a, input logic [7:0] e, input string s);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk(s, e, rdata);
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 3000 && irq !== 1'b1; i++)
			@(posedge clk);
		chk("irq", 8'h01, {7'h0, irq});
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rreg(ADDR_CONTROL, CONTROL_RESET, "control");
		rreg(ADDR_STATUS, 8'h00, "status");
		rreg(2'h3, 8'h00, "unmapped");
		// master: every rate, each with another clock mode
		for (int m = 0; m < 4; m++) begin
			pol = m[1];
			h = (m == 0) ? 1 : (m == 1) ? 2 : (m == 2) ? 8 : 16;
			wreg(ADDR_CONTROL, 8'hd0 | 8'(m) | 8'(m << 2));
			// a polarity change reaches the edge counter one clock late
			repeat (2) @(posedge clk);
			spi_peer_i.arm(8'h3c ^ 8'(m), m[1], m[0]);
			chk("sck idle", {7'h0, pol}, {7'h0, sck_w});
			chk("miso oe", 8'h00, {7'h0, miso_oe});
			e0 = edges;
			a0 = act;
			wreg(ADDR_DATA, 8'ha5 ^ 8'(m));
			wait_irq();
			repeat (20) @(posedge clk);
			chk("edges", 8'h10, 8'(edges - e0));
			chk("active", 8'(8 * h), 8'(act - a0));
			chk("sck idle", {7'h0, pol}, {7'h0, sck_w});
			chk("peer rx", 8'ha5 ^ 8'(m), spi_peer_i.rx);
			rreg(ADDR_STATUS, 8'h80, "status");
			rreg(ADDR_DATA, 8'h3c ^ 8'(m), "data");
		end
		// collision, then a write while done is unacknowledged
		pol = 1'b0;
		wreg(ADDR_CONTROL, 8'hd3);
		@(posedge clk);
		spi_peer_i.arm(8'h5a, 1'b0, 1'b0);
		wreg(ADDR_DATA, 8'h11);
		repeat (8) @(posedge clk);
		wreg(ADDR_DATA, 8'h22);
		wait_irq();
		repeat (20) @(posedge clk);
		chk("peer rx", 8'h11, spi_peer_i.rx);
		e0 = edges;
		wreg(ADDR_DATA, 8'h33);
		repeat (40) @(posedge clk);
		chk("edges", 8'h00, 8'(edges - e0));
		rreg(ADDR_STATUS, 8'hc0, "status");
		rreg(ADDR_DATA, 8'h5a, "data");
		rreg(ADDR_STATUS, 8'h00, "status");
		// second master pulls select low
		wreg(ADDR_CONTROL, 8'hd0);
		spi_peer_i.o_ss_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk("irq", 8'h01, {7'h0, irq});
		chk("sck oe", 8'h00, {7'h0, sck_oe});
		rreg(ADDR_STATUS, 8'h10, "status");
		rreg(ADDR_CONTROL, 8'h80, "control");
		spi_peer_i.o_ss_n <= 1'b1;
		wreg(ADDR_CONTROL, 8'h00);
		rreg(ADDR_STATUS, 8'h00, "status");
		// slave, both phases
		for (int c = 0; c < 2; c++) begin
			wreg(ADDR_CONTROL, 8'h40 | 8'(c << 2));
			wreg(ADDR_DATA, 8'h96 + 8'(c));
			chk("miso oe", 8'h00, {7'h0, miso_oe});
			spi_peer_i.xfer(8'h5a + 8'(c), c[0], pr);
			chk("slave tx", 8'h96 + 8'(c), pr);
			repeat (4) @(posedge clk);
			rreg(ADDR_STATUS, 8'h80, "status");
			rreg(ADDR_DATA, 8'h5a + 8'(c), "data");
		end
		// second byte lands while done is still set
		spi_peer_i.xfer(8'h71, 1'b1, pr);
		spi_peer_i.xfer(8'h72, 1'b1, pr);
		repeat (4) @(posedge clk);
		chk("overrun", 8'h01, {7'h0, ovr_seen});
		rreg(ADDR_STATUS, 8'h80, "status");
		rreg(ADDR_DATA, 8'h71, "data");
		end_of_test();
	end
endmodule
